// [logic/dpsel_ref_select.v]
// reference input selection and switchover control
`include "dpsel_defs.vh"
`default_nettype none
module dpsel_ref_select #(
  parameter VTMR_W = 16,
  parameter TICK_CYC = `DPSEL_TICK_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [2:0] mon_flag0,
  input wire [2:0] mon_flag1,
  input wire manual_select_pin,
  input wire xo_in_range,
  input wire hist_valid,
  output wire sel_ref,
  output wire [1:0] loop_state,
  output wire [1:0] status_pins,
  output wire oscillator_loss_flag,
  output wire xo_valid,
  output reg switch_pulse,
  output reg phase_cancel_pulse,
  output reg freq_smooth_pulse,
  output reg fastlock_pulse,
  output wire slew_active,
  output wire [15:0] phase_slew_threshold
);
  reg [9:0] ctrl_r;
  reg [7:0] prio_r;
  reg [VTMR_W-1:0] vtmr_r;
  reg [31:0] slew_r;
  reg [5:0] mon_en_r;
  reg pin_s1_r;
  reg pin_s2_r;
  reg xo_s1_r;
  reg xo_s2_r;
  reg xo_loss_r;
  reg [15:0] tick_cnt_r;
  reg tick_r;
  reg [VTMR_W-1:0] vcnt0_r;
  reg [VTMR_W-1:0] vcnt1_r;
  reg valid0_r;
  reg valid1_r;
  reg sel_r;
  reg sel_nxt;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [15:0] slew_cnt_r;
  wire [1:0] mode;
  wire man_choice;
  wire clr0;
  wire clr1;
  wire [1:0] best;
  wire cur_valid;
  wire man_valid;
  wire [1:0] lost_state;
  wire do_switch;
  wire hold_exit;
  wire hitless_ok;
  wire step_event;
  wire slew_load;
  wire fl_need;

  // per-input priority pick; returns {found, index}
  function [1:0] pick_best;
    input v0;
    input v1;
    input [2:0] p0;
    input [2:0] p1;
    reg e0;
    reg e1;
    begin
      e0 = v0 && (p0 != 3'h0);
      e1 = v1 && (p1 != 3'h0);
      if (e0 && e1) begin
        // lower number wins, tie goes to input zero
        pick_best = (p1 < p0) ? 2'h3 : 2'h2;
      end else if (e0) begin
        pick_best = 2'h2;
      end else if (e1) begin
        pick_best = 2'h3;
      end else begin
        pick_best = 2'h0;
      end
    end
  endfunction

  // monitors clear: only enabled monitors count
  function mon_clear;
    input [2:0] flags;
    input [2:0] en;
    begin
      mon_clear = ~|(flags & en);
    end
  endfunction

  // validity of one input by index
  function in_valid;
    input idx;
    input v0;
    input v1;
    begin
      in_valid = idx ? v1 : v0;
    end
  endfunction

  assign mode = ctrl_r[`DPSEL_C_MODE_HI:`DPSEL_C_MODE_LO];
  // pin path is synchronised; register path is on-clock
  assign man_choice = ctrl_r[`DPSEL_C_MPIN] ? pin_s2_r : ctrl_r[`DPSEL_C_MSEL];
  assign clr0 = mon_clear(mon_flag0, mon_en_r[2:0]);
  assign clr1 = mon_clear(mon_flag1, mon_en_r[5:3]);
  assign best = pick_best(valid0_r, valid1_r, prio_r[2:0], prio_r[6:4]);
  assign cur_valid = in_valid(sel_r, valid0_r, valid1_r);
  assign man_valid = in_valid(man_choice, valid0_r, valid1_r);
  assign xo_valid = ctrl_r[`DPSEL_C_XBYP] | ~xo_loss_r;
  assign oscillator_loss_flag = xo_loss_r;
  assign lost_state = hist_valid ? `DPSEL_S_HOLD : `DPSEL_S_FREE;

  // register writes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DPSEL_CTRL_RST;
      prio_r <= `DPSEL_PRIO_RST;
      vtmr_r <= `DPSEL_VTMR_RST;
      slew_r <= `DPSEL_SLEW_RST;
      mon_en_r <= `DPSEL_MON_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `DPSEL_A_CTRL: ctrl_r <= reg_wdata[9:0];
        // spare bits of each priority nibble read back as zero
        `DPSEL_A_PRIO: prio_r <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
        `DPSEL_A_VTMR: vtmr_r <= reg_wdata[VTMR_W-1:0];
        `DPSEL_A_SLEW: slew_r <= reg_wdata;
        `DPSEL_A_MON: mon_en_r <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `DPSEL_A_CTRL: reg_rdata <= {22'h000000, ctrl_r};
        `DPSEL_A_PRIO: reg_rdata <= {24'h000000, prio_r};
        `DPSEL_A_VTMR: reg_rdata <= {{(32-VTMR_W){1'b0}}, vtmr_r};
        `DPSEL_A_SLEW: reg_rdata <= slew_r;
        `DPSEL_A_MON: reg_rdata <= {26'h0000000, mon_en_r};
        `DPSEL_A_STAT: begin
          // live snapshot; nothing clears on read
          reg_rdata <= {24'h000000, slew_active, xo_valid, xo_loss_r,
            valid1_r, valid0_r, st_r, sel_r};
        end
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // two-stage synchroniser for the select pin
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= manual_select_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // two-stage synchroniser for the rc detector; loss starts set
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xo_s1_r <= 1'b0;
      xo_s2_r <= 1'b0;
      xo_loss_r <= 1'b1;
    end else begin
      xo_s1_r <= xo_in_range;
      xo_s2_r <= xo_s1_r;
      // bypass deliberately not looked at here
      xo_loss_r <= ~xo_s2_r;
    end
  end

  // microsecond tick for validation and slew timers
  // an enable pulse, so the block stays in one clock domain
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_CYC[15:0] - 16'h0001) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // qualification: any enabled flag restarts the timer, drops validity at once
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vcnt0_r <= {VTMR_W{1'b0}};
      valid0_r <= 1'b0;
    end else if (!clr0) begin
      vcnt0_r <= {VTMR_W{1'b0}};
      valid0_r <= 1'b0;
    end else if (vcnt0_r >= vtmr_r) begin
      valid0_r <= 1'b1;
    end else if (tick_r) begin
      vcnt0_r <= vcnt0_r + {{(VTMR_W-1){1'b0}}, 1'b1};
    end
  end

  // same qualification for input one
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vcnt1_r <= {VTMR_W{1'b0}};
      valid1_r <= 1'b0;
    end else if (!clr1) begin
      vcnt1_r <= {VTMR_W{1'b0}};
      valid1_r <= 1'b0;
    end else if (vcnt1_r >= vtmr_r) begin
      valid1_r <= 1'b1;
    end else if (tick_r) begin
      vcnt1_r <= vcnt1_r + {{(VTMR_W-1){1'b0}}, 1'b1};
    end
  end

  // selection decision; only qualified validity is used, so
  // gaps tolerated by the monitors never disturb the choice
  always @* begin
    sel_nxt = sel_r;
    st_nxt = st_r;
    if (!xo_valid) begin
      st_nxt = `DPSEL_S_FREE;
    end else begin
      case (mode)
        `DPSEL_M_AREV: begin
          if (best[1]) begin
            sel_nxt = best[0];
            st_nxt = `DPSEL_S_TRACK;
          end else begin
            st_nxt = lost_state;
          end
        end
        `DPSEL_M_ANREV: begin
          // a better input waits until the current one fails
          if (st_r == `DPSEL_S_TRACK && cur_valid) begin
            sel_nxt = sel_r;
          end else if (best[1]) begin
            sel_nxt = best[0];
            st_nxt = `DPSEL_S_TRACK;
          end else begin
            st_nxt = lost_state;
          end
        end
        `DPSEL_M_MFALL: begin
          if (man_valid) begin
            sel_nxt = man_choice;
            st_nxt = `DPSEL_S_TRACK;
          end else if (best[1]) begin
            sel_nxt = best[0];
            st_nxt = `DPSEL_S_TRACK;
          end else begin
            st_nxt = lost_state;
          end
        end
        default: begin
          if (man_valid) begin
            sel_nxt = man_choice;
            st_nxt = `DPSEL_S_TRACK;
          end else begin
            st_nxt = lost_state;
          end
        end
      endcase
    end
  end

  assign do_switch = (st_nxt == `DPSEL_S_TRACK) && (st_r == `DPSEL_S_TRACK) && (sel_nxt != sel_r);
  assign hold_exit = (st_nxt == `DPSEL_S_TRACK) && (st_r != `DPSEL_S_TRACK);
  // pulse-per-second inputs lose hitless handling under zero-delay sync
  assign hitless_ok = ~(ctrl_r[`DPSEL_C_PPS] & ctrl_r[`DPSEL_C_ZDS]);
  // any step that reaches the loop: a switch or a re-entry into tracking
  assign step_event = do_switch | hold_exit;
  // locked switches get no slewing; cancellation covers them only when its enable bit is set
  assign slew_load = hitless_ok & ctrl_r[`DPSEL_C_SLEW] &
    (hold_exit | (do_switch & ~ctrl_r[`DPSEL_C_FLCK]));
  // no hitless scheme: step rides the fast-lock bandwidth
  assign fl_need = step_event & (~hitless_ok | (~ctrl_r[`DPSEL_C_PCAN] & ~ctrl_r[`DPSEL_C_SLEW]));

  // state and switchover on a single edge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 1'b0;
      st_r <= `DPSEL_S_FREE;
      switch_pulse <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      st_r <= st_nxt;
      switch_pulse <= step_event;
    end
  end

  // hitless treatment of each switch event
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_cancel_pulse <= 1'b0;
      freq_smooth_pulse <= 1'b0;
      fastlock_pulse <= 1'b0;
    end else begin
      phase_cancel_pulse <= 1'b0;
      freq_smooth_pulse <= 1'b0;
      fastlock_pulse <= fl_need;
      if (do_switch && hitless_ok && ctrl_r[`DPSEL_C_PCAN]) begin
        if (ctrl_r[`DPSEL_C_FLCK]) begin
          phase_cancel_pulse <= 1'b1;
        end else begin
          freq_smooth_pulse <= 1'b1;
        end
      end
    end
  end

  // slew timer; the threshold itself is only passed on to the loop
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slew_cnt_r <= 16'h0000;
    end else if (slew_load) begin
      slew_cnt_r <= slew_r[31:16];
    end else if (tick_r && slew_cnt_r != 16'h0000) begin
      slew_cnt_r <= slew_cnt_r - 16'h0001;
    end
  end

  assign slew_active = slew_cnt_r != 16'h0000;
  assign phase_slew_threshold = slew_r[15:0];
  assign sel_ref = sel_r;
  assign status_pins = {st_r == `DPSEL_S_TRACK, sel_r};
  assign loop_state = st_r;
endmodule
`default_nettype wire

// [pkg/dpsel_defs.vh]
// register map, fields and timing constants for the reference selector
`ifndef DPSEL_DEFS_VH
`define DPSEL_DEFS_VH
`define DPSEL_A_CTRL 8'h00
`define DPSEL_A_PRIO 8'h04
`define DPSEL_A_VTMR 8'h08
`define DPSEL_A_SLEW 8'h0C
`define DPSEL_A_STAT 8'h10
`define DPSEL_A_MON 8'h14
`define DPSEL_C_MODE_LO 0
`define DPSEL_C_MODE_HI 1
`define DPSEL_C_MSEL 2
`define DPSEL_C_MPIN 3
`define DPSEL_C_PCAN 4
`define DPSEL_C_SLEW 5
`define DPSEL_C_ZDS 6
`define DPSEL_C_XBYP 7
`define DPSEL_C_PPS 8
`define DPSEL_C_FLCK 9
`define DPSEL_CTRL_RST 10'h000
`define DPSEL_PRIO_RST 8'h11
`define DPSEL_VTMR_RST 16'h0064
`define DPSEL_SLEW_RST 32'h0010_0100
`define DPSEL_MON_RST 6'h00
`define DPSEL_M_AREV 2'h0
`define DPSEL_M_ANREV 2'h1
`define DPSEL_M_MFALL 2'h2
`define DPSEL_M_MHOLD 2'h3
`define DPSEL_S_FREE 2'h0
`define DPSEL_S_TRACK 2'h1
`define DPSEL_S_HOLD 2'h2
`define DPSEL_CLK_HZ 50000000
`define DPSEL_TICK_NS 1000
`define DPSEL_TICK_CYC ((`DPSEL_CLK_HZ / 1000000) * `DPSEL_TICK_NS / 1000)
`endif

// [verif/dpsel_ref_select_asserts.sv]
// port-level assertions for the reference selector
`include "dpsel_defs.vh"
`default_nettype none
module dpsel_ref_select_asserts (
  input wire clk_sys,
  input wire rst_n,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire xo_in_range,
  input wire hist_valid,
  input wire sel_ref,
  input wire [1:0] loop_state,
  input wire [1:0] status_pins,
  input wire oscillator_loss_flag,
  input wire xo_valid,
  input wire switch_pulse,
  input wire phase_cancel_pulse,
  input wire freq_smooth_pulse,
  input wire fastlock_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // two sync stages plus the flag register
  sequence s_xo_up; xo_in_range [*3]; endsequence
  sequence s_xo_down; !xo_in_range [*3]; endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_xo_clear; s_xo_up |=> !oscillator_loss_flag; endproperty
  a_xo_clear: assert property (p_xo_clear) else $error("loss flag stuck");
  property p_xo_lost; s_xo_down |=> oscillator_loss_flag; endproperty
  a_xo_lost: assert property (p_xo_lost) else $error("loss flag missing");
  property p_free; !xo_valid |=> loop_state == `DPSEL_S_FREE; endproperty
  a_free: assert property (p_free) else $error("tracking without oscillator");
  property p_pins; status_pins == {loop_state == `DPSEL_S_TRACK, sel_ref}; endproperty
  a_pins: assert property (p_pins) else $error("status pins disagree");
  property p_pulse; switch_pulse |=> !switch_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("switch pulse too long");
  property p_kind; (phase_cancel_pulse || freq_smooth_pulse || fastlock_pulse) |-> switch_pulse; endproperty
  a_kind: assert property (p_kind) else $error("hitless pulse without switch");
  property p_one; $onehot0({phase_cancel_pulse, freq_smooth_pulse, fastlock_pulse}); endproperty
  a_one: assert property (p_one) else $error("two hitless schemes at once");
  property p_hold; $changed(loop_state) && loop_state == `DPSEL_S_HOLD |-> $past(hist_valid); endproperty
  a_hold: assert property (p_hold) else $error("holdover without history");
endmodule
bind dpsel_ref_select dpsel_ref_select_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .xo_in_range(xo_in_range), .hist_valid(hist_valid), .sel_ref(sel_ref),
  .loop_state(loop_state), .status_pins(status_pins), .oscillator_loss_flag(oscillator_loss_flag),
  .xo_valid(xo_valid), .switch_pulse(switch_pulse), .phase_cancel_pulse(phase_cancel_pulse),
  .freq_smooth_pulse(freq_smooth_pulse), .fastlock_pulse(fastlock_pulse));
`default_nettype wire

// [verif/dpsel_ref_select_test.sv]
// self-checking bench for the reference selector
`include "dpsel_defs.vh"
`default_nettype none
module dpsel_ref_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] fre = `DPSEL_S_FREE;
  localparam logic [1:0] trk = `DPSEL_S_TRACK;
  localparam logic [1:0] hld = `DPSEL_S_HOLD;
  logic clk_sys, rst_n, reg_wr, reg_rd, pin, xo_in, hist, fault0, fault1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [2:0] p0, p1;
  logic [9:0] ctl;
  wire [31:0] reg_rdata;
  wire [2:0] mf0, mf1;
  wire [15:0] thr;
  wire [1:0] loop_state;
  wire sel_ref, osc_loss, xo_valid;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 748;
  int i;
  int n_pc = 0;
  int n_fl = 0;
  int a_pc;
  int a_fl;
  wire pc_p;
  wire fl_p;
  dpsel_ref_src i_src (.clk_sys(clk_sys), .rst_n(rst_n), .fault0(fault0), .fault1(fault1), .mon_flag0(mf0),
    .mon_flag1(mf1));
  dpsel_ref_select #(.TICK_CYC(2)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mon_flag0(mf0),
    .mon_flag1(mf1), .manual_select_pin(pin), .xo_in_range(xo_in), .hist_valid(hist), .sel_ref(sel_ref),
    .loop_state(loop_state), .status_pins(), .oscillator_loss_flag(osc_loss), .xo_valid(xo_valid),
    .switch_pulse(), .phase_cancel_pulse(pc_p), .freq_smooth_pulse(), .fastlock_pulse(fl_p), .slew_active(),
    .phase_slew_threshold(thr));
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // one-cycle hitless pulses are counted so checks can see them
  always @(posedge clk_sys) begin
    if (pc_p === 1'h1) n_pc <= n_pc + 1;
    if (fl_p === 1'h1) n_fl <= n_fl + 1;
  end
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(negedge clk_sys);
    chk(reg_rdata, e);
  endtask
  task automatic flt(input logic a, input logic b);
    @(posedge clk_sys);
    fault0 <= a;
    fault1 <= b;
  endtask
  // m low: selection is meaningless outside tracking
  task automatic wt(input logic s, input logic [1:0] st, input logic m);
    int k;
    k = 0;
    while (k < 500 && !(loop_state === st && (!m || sel_ref === s))) begin
      @(negedge clk_sys);
      k++;
    end
    chk({29'h0, loop_state, m ? sel_ref : s}, {29'h0, st, s});
    if (k == 500) begin
      n_fail++;
      conclude();
    end
  endtask
  function automatic logic best(input logic [2:0] a, input logic [2:0] b);
    if (a == 3'h0) return 1'h1;
    if (b == 3'h0) return 1'h0;
    return b < a;
  endfunction
  initial begin
    {rst_n, reg_wr, reg_rd, pin, hist, fault0, fault1} = 7'h00;
    {reg_addr, reg_wdata} = 40'h0;
    xo_in = 1'h1;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(`DPSEL_A_CTRL, 32'h0);
    rd(`DPSEL_A_PRIO, 32'h11);
    rd(`DPSEL_A_VTMR, 32'h64);
    rd(`DPSEL_A_SLEW, 32'h0010_0100);
    rd(`DPSEL_A_MON, 32'h0);
    rd(8'h20, 32'h0);
    wr(`DPSEL_A_VTMR, 32'h3);
    wr(`DPSEL_A_MON, 32'h1B);
    wr(`DPSEL_A_SLEW, 32'h0020_0ABC);
    @(negedge clk_sys);
    chk({16'h0, thr}, 32'hABC);
    wr(`DPSEL_A_CTRL, 32'h210);
    wt(1'h0, trk, 1'h1);
    wr(`DPSEL_A_PRIO, 32'h12);
    wt(1'h1, trk, 1'h1);
    flt(1'h0, 1'h1);
    wt(1'h0, trk, 1'h1);
    wr(`DPSEL_A_CTRL, 32'h1);
    flt(1'h0, 1'h0);
    // well past the six-cycle validation time
    repeat (40) @(posedge clk_sys);
    wt(1'h0, trk, 1'h1);
    flt(1'h1, 1'h0);
    wt(1'h1, trk, 1'h1);
    wr(`DPSEL_A_CTRL, 32'h0);
    wr(`DPSEL_A_PRIO, 32'h2);
    flt(1'h0, 1'h0);
    wt(1'h0, trk, 1'h1);
    flt(1'h1, 1'h0);
    wt(1'h0, fre, 1'h0);
    @(posedge clk_sys);
    hist <= 1'h1;
    wr(`DPSEL_A_PRIO, 32'h11);
    wr(`DPSEL_A_CTRL, 32'h7);
    flt(1'h0, 1'h0);
    wt(1'h1, trk, 1'h1);
    flt(1'h0, 1'h1);
    wt(1'h1, hld, 1'h0);
    flt(1'h0, 1'h0);
    wt(1'h1, trk, 1'h1);
    wr(`DPSEL_A_CTRL, 32'h6);
    flt(1'h0, 1'h1);
    wt(1'h0, trk, 1'h1);
    flt(1'h0, 1'h0);
    wt(1'h1, trk, 1'h1);
    wr(`DPSEL_A_CTRL, 32'hE);
    wt(1'h0, trk, 1'h1);
    @(posedge clk_sys);
    pin <= 1'h1;
    wt(1'h1, trk, 1'h1);
    @(posedge clk_sys);
    xo_in <= 1'h0;
    wt(1'h0, fre, 1'h0);
    wr(`DPSEL_A_CTRL, 32'h8E);
    @(negedge clk_sys);
    chk({30'h0, osc_loss, xo_valid}, 32'h3);
    @(posedge clk_sys);
    xo_in <= 1'h1;
    hist <= 1'h0;
    for (i = 0; i < 8; i++) begin
      p0 = 3'($random(seed));
      p1 = 3'($random(seed));
      ctl = 10'($random(seed)) & 10'h230;
      wr(`DPSEL_A_PRIO, {25'h0, p1, 1'h0, p0});
      wr(`DPSEL_A_CTRL, {22'h0, ctl});
      if (p0 == 3'h0 && p1 == 3'h0) begin
        wt(1'h0, fre, 1'h0);
      end else begin
        wt(best(p0, p1), trk, 1'h1);
      end
    end
    wr(`DPSEL_A_PRIO, 32'h11);
    wr(`DPSEL_A_CTRL, 32'h210);
    wt(1'h0, trk, 1'h1);
    wr(`DPSEL_A_CTRL, 32'h350);
    a_pc = n_pc;
    a_fl = n_fl;
    wr(`DPSEL_A_PRIO, 32'h12);
    wt(1'h1, trk, 1'h1);
    repeat (2) @(posedge clk_sys);
    chk(n_pc - a_pc, 32'h0);
    chk(n_fl - a_fl, 32'h1);
    wr(`DPSEL_A_CTRL, 32'h210);
    a_pc = n_pc;
    a_fl = n_fl;
    wr(`DPSEL_A_PRIO, 32'h11);
    wt(1'h0, trk, 1'h1);
    repeat (2) @(posedge clk_sys);
    chk(n_pc - a_pc, 32'h1);
    chk(n_fl - a_fl, 32'h0);
    repeat (80) @(posedge clk_sys);
    rd(`DPSEL_A_STAT, 32'h5A);
    conclude();
  end
endmodule
`default_nettype wire

// [verif/dpsel_ref_src.sv]
// far-side model: reference sources feeding the monitor flags
`default_nettype none
module dpsel_ref_src (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fault0,
  input wire logic fault1,
  output wire logic [2:0] mon_flag0,
  output wire logic [2:0] mon_flag1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic noise_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      noise_r <= 1'h0;
    end else begin
      noise_r <= ~noise_r;
    end
  end
  // phase-valid bit chatters: a masked monitor must never count
  assign mon_flag0 = {noise_r, fault0, fault0};
  assign mon_flag1 = {~noise_r, fault1, fault1};
endmodule
`default_nettype wire
